// ---- design/esis_pkg.sv ----
package esis_pkg;

	localparam int unsigned CLK_HZ         = 50_000_000;
	localparam int unsigned TICK_PERIOD_MS = 1000;
	localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_PERIOD_MS;

	localparam int unsigned NUM_TMR  = 4;
	localparam int unsigned TMR_COOL = 0;
	localparam int unsigned TMR_ISTA = 1;
	localparam int unsigned TMR_ISTO = 2;
	localparam int unsigned TMR_SFAIL = 3;
	localparam int unsigned TMR_W    = 17;

	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_COOLDOWN  = 8'h04;
	localparam logic [7:0] ADDR_STOPFAIL  = 8'h08;
	localparam logic [7:0] ADDR_IDLE_STA  = 8'h0C;
	localparam logic [7:0] ADDR_IDLE_STO  = 8'h10;
	localparam logic [7:0] ADDR_GOV_OFS   = 8'h14;
	localparam logic [7:0] ADDR_STATUS    = 8'h18;

	localparam int unsigned CTRL_IDLE_EN   = 0;
	localparam int unsigned CTRL_ISTA_EN   = 1;
	localparam int unsigned CTRL_ISTO_EN   = 2;
	localparam int unsigned CTRL_IINT_EN   = 3;
	localparam int unsigned CTRL_SFAIL_EN  = 4;
	localparam int unsigned CTRL_MODE_LSB  = 5;
	localparam int unsigned CTRL_APP_LSB   = 8;
	localparam int unsigned CTRL_SHIFT     = 11;
	localparam int unsigned CTRL_W         = 12;

	localparam int unsigned STAT_STATE_LSB = 0;
	localparam int unsigned STAT_SFAIL     = 8;
	localparam int unsigned STAT_IDLE      = 9;

	localparam logic [11:0] CTRL_RST      = 12'h010;
	localparam logic [15:0] COOLDOWN_RST  = 16'h00F0;
	localparam logic [15:0] STOPFAIL_RST  = 16'h001E;
	localparam logic [13:0] IDLE_STA_RST  = 14'h0BB8;
	localparam logic [13:0] IDLE_STO_RST  = 14'h0BB8;
	localparam logic [7:0]  GOV_OFS_RST   = 8'h00;
	localparam logic [16:0] TENTH_MIN_SEC = 17'h00006;

	typedef enum logic [1:0] {
		MODE_AUTO   = 2'b00,
		MODE_OPER   = 2'b01,
		MODE_MANUAL = 2'b10
	} esis_mode_t;

	typedef enum logic [2:0] {
		APP_ISLAND = 3'b000,
		APP_FIXED  = 3'b001,
		APP_LTO    = 3'b010,
		APP_EXPORT = 3'b011,
		APP_PEAK   = 3'b100,
		APP_AMF    = 3'b101
	} esis_app_t;

	typedef enum logic [2:0] {
		ST_STOPPED   = 3'b000,
		ST_RUN       = 3'b001,
		ST_COOL      = 3'b010,
		ST_IDLE_STOP = 3'b011,
		ST_STOPPING  = 3'b100
	} esis_state_t;

endpackage

// ---- design/esis_tmr_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface esis_tmr_if;
	import esis_pkg::*;
	logic              tick;
	logic              restart;
	logic [TMR_W-1:0]  limit;
	logic              zero_inf;
	logic              done;
	modport ctl (output tick, output restart, output limit, output zero_inf, input done);
	modport tmr (input tick, input restart, input limit, input zero_inf, output done);
endinterface
`default_nettype wire

// ---- design/esis_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module esis_timer
	import esis_pkg::*;
(
	input  wire logic  mclk_i,
	input  wire logic  reset_i,
	esis_tmr_if.tmr    t
);
	logic [TMR_W-1:0] cnt_ff;
	logic [TMR_W-1:0] nxt_cnt;
	wire              at_max = &cnt_ff;

	// Saturating so a long wait never wraps into a false expiry.
	assign nxt_cnt = t.restart ? '0 : ((t.tick && !at_max) ? cnt_ff + 1'b1 : cnt_ff);
	assign t.done  = (t.limit == '0) ? !t.zero_inf : (cnt_ff >= t.limit);

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule // esis_timer
`default_nettype wire

// ---- design/esis_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) Stop command starts stop, cooldown first normally.
// (R2) Cooldown configurable, default 240 s, zero endless.
// (R3) Stop button cools down; second press stops.
// (R4) Emergency stop skips cooldown, opens breaker.
// (R5) Only cooldown interruptible; restart waits stopped. Code also lets thermal hold return idle stop to run.
// (R6) Mains failure cancels cooldown in auto failover.
// (R7) Operator start cancels cooldown, engine keeps running.
// (R8) Auto digital start or peak overshoot cancels.
// (R9) Breaker close cancels cooldown in operator/manual.
// (R10) Stopped engine returns governor output to offset.
// (R11) Stop-failure alarm, enabled, 30 s default.
// (R12) Idle run drives idle-select signal to governor.
// (R13) Low-speed input selects speed, never blocks stop.
// (R14) Thermal hold starts engine and refuses stop.
// (R15) Low-speed input outranks expired idle start timer.
// (R16) Idle start timer holds idle, default 300 min.
// (R17) Idle stop timer idles before final stop.
// (R18) Low-speed active means idle, released means nominal.
// (R19) Idle interrupt: start gives nominal, stop stops.
// (R20) Alarm inhibits apply, oil pressure stays active.
// (R21) Installation asserts running feedback during idle.
// (R22) Timers use one-second tick, restart per entry.
module esis_top
	import esis_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYCLES
)
(
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	input  wire logic        auto_stop_i,
	input  wire logic        trip_stop_i,
	input  wire logic        stop_btn_i,
	input  wire logic        remote_stop_i,
	input  wire logic        estop_i,
	input  wire logic        start_btn_i,
	input  wire logic        remote_start_i,
	input  wire logic        dig_start_i,
	input  wire logic        peak_over_sp_i,
	input  wire logic        mains_fail_i,
	input  wire logic        gb_close_btn_i,
	input  wire logic        remote_gb_close_i,
	input  wire logic        low_speed_i,
	input  wire logic        thermal_hold_i,
	input  wire logic        running_fb_i,
	input  wire logic        alarm_inhibit_i,
	input  wire logic [7:0]  gov_setpoint_i,
	output logic             run_req_o,
	output logic             generator_breaker_open_o,
	output logic             idle_o,
	output logic      [7:0]  gov_out_o,
	output logic             stop_fail_o,
	output logic             inhibit_o,
	output logic             oil_inhibit_o,
	output logic      [2:0]  state_o
);

	localparam int unsigned TICK_W = $clog2(TICK_CYC + 1);

	esis_state_t          state_ff;
	esis_state_t          nxt_state;
	logic [CTRL_W-1:0]    ctrl_ff;
	logic [15:0]          cooldown_ff;
	logic [15:0]          stopfail_ff;
	logic [13:0]          idle_sta_ff;
	logic [13:0]          idle_sto_ff;
	logic [7:0]           gov_ofs_ff;
	logic                 sfail_ff;
	logic                 ista_act_ff;
	logic                 ovr_ff;
	logic                 idle_ff;
	logic                 gb_open_ff;
	logic [7:0]           gov_ff;
	logic                 inh_ff;
	logic                 oil_inh_ff;
	logic [31:0]          rdata_ff;
	logic [TICK_W-1:0]    tick_cnt_ff;
	logic [NUM_TMR-1:0]   tmr_restart;
	logic [NUM_TMR-1:0]   tmr_done;
	logic [TMR_W-1:0]     tmr_limit [NUM_TMR];

	esis_tmr_if tmr_bus [NUM_TMR] ();

	// One-second tick shared by every sequence timer.
	wire tick = (tick_cnt_ff == TICK_W'(TICK_CYC - 1)); // R22

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 1'b1;
		end
	end

	wire idle_en  = ctrl_ff[CTRL_IDLE_EN];
	wire ista_en  = ctrl_ff[CTRL_ISTA_EN];
	wire isto_en  = ctrl_ff[CTRL_ISTO_EN];
	wire iint_en  = ctrl_ff[CTRL_IINT_EN];
	wire sfail_en = ctrl_ff[CTRL_SFAIL_EN];
	wire [1:0] mode = ctrl_ff[CTRL_MODE_LSB +: 2];
	wire [2:0] app  = ctrl_ff[CTRL_APP_LSB +: 3];
	wire shift_on = ctrl_ff[CTRL_SHIFT];

	wire m_auto   = (mode == MODE_AUTO);
	wire m_oper   = (mode == MODE_OPER);
	wire m_sm     = m_oper || (mode == MODE_MANUAL);
	wire app_dig  = (app == APP_ISLAND) || (app == APP_FIXED) || (app == APP_LTO) || (app == APP_EXPORT);

	wire oper_start = m_oper && (start_btn_i || remote_start_i);
	wire user_stop  = m_sm && (stop_btn_i || remote_stop_i);
	wire mains_ev   = m_auto && mains_fail_i && ((app == APP_AMF) || shift_on); // R6
	wire auto_start = m_auto && ((dig_start_i && app_dig) || (peak_over_sp_i && (app == APP_PEAK))); // R8
	wire gb_close   = m_sm && (gb_close_btn_i || remote_gb_close_i); // R9
	wire cancel_ev  = mains_ev || oper_start || auto_start || gb_close; // R7
	wire start_ev   = mains_ev || oper_start || auto_start || thermal_hold_i; // R14
	wire soft_stop  = user_stop || (m_auto && auto_stop_i); // R1
	wire idle_stop_press = m_oper && iint_en && idle_ff && user_stop; // R19
	wire idle_start_press = m_oper && iint_en && idle_ff && oper_start; // R19

	// Low-speed input plays no part here, so it can never hold off a stop.
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_STOPPED: begin
				if (start_ev && !estop_i) begin // R5
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (estop_i || (idle_stop_press && !thermal_hold_i)) begin // R4 R19
					nxt_state = ST_STOPPING;
				end else if (trip_stop_i || (soft_stop && !thermal_hold_i)) begin // R14 R13
					nxt_state = ST_COOL; // R1
				end
			end
			ST_COOL: begin
				if (estop_i) begin // R4
					nxt_state = ST_STOPPING;
				end else if (thermal_hold_i || cancel_ev) begin // R5
					nxt_state = ST_RUN;
				end else if (user_stop) begin // R3
					nxt_state = ST_STOPPING;
				end else if (tmr_done[TMR_COOL]) begin // R2
					nxt_state = isto_en && idle_en ? ST_IDLE_STOP : ST_STOPPING; // R17
				end
			end
			ST_IDLE_STOP: begin
				if (estop_i) begin // R4
					nxt_state = ST_STOPPING;
				end else if (thermal_hold_i) begin // R14
					nxt_state = ST_RUN;
				end else if (tmr_done[TMR_ISTO]) begin // R17
					nxt_state = ST_STOPPING;
				end
			end
			ST_STOPPING: begin
				if (!running_fb_i) begin // R21
					nxt_state = ST_STOPPED;
				end
			end
			default: begin
				nxt_state = ST_STOPPING;
			end
		endcase
	end

	wire entering = (nxt_state != state_ff);

	assign tmr_restart[TMR_COOL]  = entering && (nxt_state == ST_COOL); // R22
	assign tmr_restart[TMR_ISTA]  = entering && (state_ff == ST_STOPPED); // R22
	assign tmr_restart[TMR_ISTO]  = entering && (nxt_state == ST_IDLE_STOP); // R22
	assign tmr_restart[TMR_SFAIL] = entering && (nxt_state == ST_STOPPING); // R22

	assign tmr_limit[TMR_COOL]  = {1'b0, cooldown_ff}; // R2
	assign tmr_limit[TMR_ISTA]  = {3'h0, idle_sta_ff} * TENTH_MIN_SEC; // R16
	assign tmr_limit[TMR_ISTO]  = {3'h0, idle_sto_ff} * TENTH_MIN_SEC; // R17
	assign tmr_limit[TMR_SFAIL] = {1'b0, stopfail_ff}; // R11

	genvar gi;
	generate
		for (gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
			assign tmr_bus[gi].tick     = tick;
			assign tmr_bus[gi].restart  = tmr_restart[gi];
			assign tmr_bus[gi].limit    = tmr_limit[gi];
			assign tmr_bus[gi].zero_inf = (gi == TMR_COOL); // R2
			assign tmr_done[gi]         = tmr_bus[gi].done;
			esis_timer u_timer (
				.mclk_i  (mclk_i),
				.reset_i (reset_i),
				.t       (tmr_bus[gi])
			);
		end
	endgenerate

	wire running = (state_ff == ST_RUN) || (state_ff == ST_COOL) || (state_ff == ST_IDLE_STOP);

	// The idle start window opens at every start and shuts on timeout or an idle interrupt.
	wire nxt_ista_act = tmr_restart[TMR_ISTA] ? (idle_en && ista_en) :
		(ista_act_ff && running && !tmr_done[TMR_ISTA] && !idle_start_press); // R16
	// An idle interrupt start overrides the low-speed input until it is released.
	wire nxt_ovr = idle_start_press || (ovr_ff && low_speed_i); // R19
	wire nxt_idle = idle_en && running &&
		((low_speed_i && !ovr_ff) || ista_act_ff || (state_ff == ST_IDLE_STOP)); // R15 R18 R12
	wire nxt_gb_open = estop_i || (gb_open_ff && (state_ff != ST_STOPPED)); // R4
	wire sfail_hit = sfail_en && (state_ff == ST_STOPPING) && tmr_done[TMR_SFAIL]; // R11

	// Register access decode.
	wire wr_ctrl  = wr_i && (addr_i == ADDR_CTRL);
	wire wr_cool  = wr_i && (addr_i == ADDR_COOLDOWN);
	wire wr_sfl   = wr_i && (addr_i == ADDR_STOPFAIL);
	wire wr_ista  = wr_i && (addr_i == ADDR_IDLE_STA);
	wire wr_isto  = wr_i && (addr_i == ADDR_IDLE_STO);
	wire wr_gov   = wr_i && (addr_i == ADDR_GOV_OFS);
	wire wr_stat  = wr_i && (addr_i == ADDR_STATUS);
	// Writing one clears the stop-failure flag, but a fresh failure in the same cycle wins.
	wire nxt_sfail = sfail_hit || (sfail_ff && !(wr_stat && wdata_i[STAT_SFAIL])); // R11

	wire [31:0] status_word = {22'h0, idle_ff, sfail_ff, 5'h0, state_ff};
	wire [31:0] rd_mux =
		(addr_i == ADDR_CTRL)     ? {{(32-CTRL_W){1'b0}}, ctrl_ff} :
		(addr_i == ADDR_COOLDOWN) ? {16'h0, cooldown_ff} :
		(addr_i == ADDR_STOPFAIL) ? {16'h0, stopfail_ff} :
		(addr_i == ADDR_IDLE_STA) ? {18'h0, idle_sta_ff} :
		(addr_i == ADDR_IDLE_STO) ? {18'h0, idle_sto_ff} :
		(addr_i == ADDR_GOV_OFS)  ? {24'h0, gov_ofs_ff} :
		(addr_i == ADDR_STATUS)   ? status_word : 32'h0000_0000;

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_ff <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_ff <= wdata_i[CTRL_W-1:0];
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			cooldown_ff <= COOLDOWN_RST;
		end else if (wr_cool) begin
			cooldown_ff <= wdata_i[15:0];
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			stopfail_ff <= STOPFAIL_RST;
		end else if (wr_sfl) begin
			stopfail_ff <= wdata_i[15:0];
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			idle_sta_ff <= IDLE_STA_RST;
		end else if (wr_ista) begin
			idle_sta_ff <= wdata_i[13:0];
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			idle_sto_ff <= IDLE_STO_RST;
		end else if (wr_isto) begin
			idle_sto_ff <= wdata_i[13:0];
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			gov_ofs_ff <= GOV_OFS_RST;
		end else if (wr_gov) begin
			gov_ofs_ff <= wdata_i[7:0];
		end
	end

	// Read data returns to zero after its one cycle, so a stale word is never mistaken for a fresh one.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= rd_i ? rd_mux : 32'h0000_0000;
		end
	end

	// The run request is a combinational decode of this register, not registered itself, so it can glitch on a state change.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			state_ff <= ST_STOPPED;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			sfail_ff    <= 1'b0;
			ista_act_ff <= 1'b0;
			ovr_ff      <= 1'b0;
			idle_ff     <= 1'b0;
			gb_open_ff  <= 1'b0;
		end else begin
			sfail_ff    <= nxt_sfail;
			ista_act_ff <= nxt_ista_act;
			ovr_ff      <= nxt_ovr;
			idle_ff     <= nxt_idle;
			gb_open_ff  <= nxt_gb_open;
		end
	end

	// Oil pressure alarms stay live while idling, since low oil pressure is most dangerous at idle.
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			gov_ff     <= GOV_OFS_RST;
			inh_ff     <= 1'b0;
			oil_inh_ff <= 1'b0;
		end else begin
			gov_ff     <= (state_ff == ST_STOPPED) ? gov_ofs_ff : gov_setpoint_i; // R10
			inh_ff     <= alarm_inhibit_i; // R20
			oil_inh_ff <= alarm_inhibit_i && !idle_ff; // R20
		end
	end

	assign rdata_o                  = rdata_ff;
	assign run_req_o                = running;
	assign generator_breaker_open_o = gb_open_ff;
	assign idle_o                   = idle_ff;
	assign gov_out_o                = gov_ff;
	assign stop_fail_o              = sfail_ff;
	assign inhibit_o                = inh_ff;
	assign oil_inhibit_o            = oil_inh_ff;
	assign state_o                  = state_ff;

endmodule // esis_top
`default_nettype wire

// ---- dv/esis_engine_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module esis_engine_model (
	input  wire logic mclk_i,
	input  wire logic run_req_i,
	input  wire logic stuck_i,
	output logic      running_fb_o
);
	logic [1:0] lag_ff = 2'h0;
	// Spin-up and run-down take two cycles; stuck_i models a fuel cutoff that failed.
	always @(posedge mclk_i) begin
		lag_ff <= {lag_ff[0], run_req_i | stuck_i};
	end
	assign running_fb_o = lag_ff[1];
endmodule // esis_engine_model
`default_nettype wire

// ---- dv/esis_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module esis_top_monitor
	import esis_pkg::*;
(
	input wire logic       mclk_i,
	input wire logic       reset_i,
	input wire logic [7:0] addr_i,
	input wire logic       wr_i,
	input wire logic       estop_i,
	input wire logic       trip_stop_i,
	input wire logic       stop_btn_i,
	input wire logic       thermal_hold_i,
	input wire logic       running_fb_i,
	input wire logic       alarm_inhibit_i,
	input wire logic       run_req_o,
	input wire logic       generator_breaker_open_o,
	input wire logic       idle_o,
	input wire logic       stop_fail_o,
	input wire logic       oil_inhibit_o,
	input wire logic [2:0] state_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	wire logic live;
	assign live = state_o inside {ST_RUN, ST_COOL, ST_IDLE_STOP};
	sequence s_halt_seen;
		state_o == ST_STOPPING && !running_fb_i;
	endsequence
	a_estop_no_cool: assert property (estop_i && live |=> state_o == ST_STOPPING)
		else $error("estop did not reach stopping");
	a_estop_breaker: assert property (estop_i && live |=> generator_breaker_open_o)
		else $error("breaker not opened by estop");
	a_stopping_holds: assert property (state_o == ST_STOPPING && running_fb_i |=> state_o == ST_STOPPING)
		else $error("stopping left while engine turns");
	a_halt_done: assert property (s_halt_seen |=> state_o == ST_STOPPED)
		else $error("stopped state not reached");
	a_cool_no_jump: assert property (state_o == ST_COOL |=> state_o != ST_STOPPED)
		else $error("cooldown jumped to stopped");
	a_run_request: assert property (run_req_o == live)
		else $error("run request disagrees with state");
	a_hold_refuses: assert property (thermal_hold_i && state_o == ST_RUN && !estop_i && !trip_stop_i
		&& !stop_btn_i |=> state_o == ST_RUN)
		else $error("stopped under thermal hold");
	a_fail_sticky: assert property (stop_fail_o && !(wr_i && addr_i == ADDR_STATUS) |=> stop_fail_o)
		else $error("stop failure alarm dropped");
	a_idle_needs_run: assert property (idle_o |-> $past(run_req_o))
		else $error("idle select without run request");
	a_oil_stays_live: assert property (idle_o == $past(idle_o)
		|-> oil_inhibit_o == ($past(alarm_inhibit_i) && !idle_o))
		else $error("oil inhibit wrong");
	c_idle_stop: cover property (state_o == ST_IDLE_STOP);
endmodule // esis_top_monitor
bind esis_top esis_top_monitor u_esis_top_monitor (.*);
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import esis_pkg::*;
	logic        mclk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [12:0] ev = 13'h0;
	logic        th = 1'b0;
	logic        low = 1'b0;
	logic        inh = 1'b0;
	logic        stuck = 1'b0;
	logic [7:0]  gsp = 8'hC3;
	wire  [31:0] rdata_o;
	wire  [7:0]  gov_o;
	wire  [2:0]  state_o;
	wire         run_req_o, fb, brk_o, idle_o, sfail_o, inh_o, oil_o;
	int          miscompares = 0;
	int          checked = 0;
	logic [7:0]  ra [8] = '{ADDR_CTRL, ADDR_COOLDOWN, ADDR_STOPFAIL, ADDR_IDLE_STA, ADDR_IDLE_STO, ADDR_GOV_OFS,
		ADDR_STATUS, 8'hFC};
	logic [31:0] rv [8] = '{32'h010, 32'h0F0, 32'h01E, 32'hBB8, 32'hBB8, 32'h0, 32'h0, 32'h0};
	logic [11:0] tc [13] = '{12'h030, 12'h030, 12'h030, 12'h050, 12'h050, 12'h010, 12'h410, 12'h510, 12'h010,
		12'h810, 12'h030, 12'h010, 12'h030};
	int          ts [13] = '{2, 3, 2, 3, 2, 0, 0, 0, 0, 0, 2, 1, 2};
	int          tk [13] = '{5, 6, 10, 11, 5, 7, 8, 9, 9, 9, 2, 4, 7};
	logic [2:0]  te [13] = '{ST_RUN, ST_RUN, ST_RUN, ST_RUN, ST_COOL, ST_RUN, ST_RUN, ST_RUN, ST_COOL, ST_RUN,
		ST_STOPPING, ST_STOPPING, ST_COOL};
	esis_top #(.TICK_CYC(10)) u_esis_top (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .auto_stop_i(ev[0]), .trip_stop_i(ev[1]), .stop_btn_i(ev[2]),
		.remote_stop_i(ev[3]), .estop_i(ev[4]), .start_btn_i(ev[5]), .remote_start_i(ev[6]), .dig_start_i(ev[7]),
		.peak_over_sp_i(ev[8]), .mains_fail_i(ev[9]), .gb_close_btn_i(ev[10]), .remote_gb_close_i(ev[11]),
		.low_speed_i(low), .thermal_hold_i(ev[12] | th), .running_fb_i(fb), .alarm_inhibit_i(inh),
		.gov_setpoint_i(gsp), .run_req_o(run_req_o), .generator_breaker_open_o(brk_o), .idle_o(idle_o),
		.gov_out_o(gov_o), .stop_fail_o(sfail_o), .inhibit_o(inh_o), .oil_inhibit_o(oil_o), .state_o(state_o));
	esis_engine_model u_esis_engine_model (.mclk_i(mclk_i), .run_req_i(run_req_o), .stuck_i(stuck),
		.running_fb_o(fb));
	initial forever #10 mclk_i = ~mclk_i;
	task automatic test_done();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata", rdata_o, exp);
	endtask
	task automatic pulse(input int b);
		@(posedge mclk_i);
		ev[b] <= 1'b1;
		@(posedge mclk_i);
		ev <= 13'h0;
		#1;
	endtask
	task automatic dwell(input logic [2:0] s, output int n);
		n = 0;
		while (state_o === s && n < 800) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
	endtask
	task automatic wait_st(input logic [2:0] s);
		int n;
		n = 0;
		while (state_o !== s && n < 800) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		chk("state", 32'(state_o), 32'(s));
	endtask
	// Thermal hold is the one start that works in every mode, so it brings each case to RUN.
	task automatic to_run();
		if (state_o === ST_STOPPING) wait_st(ST_STOPPED);
		if (state_o !== ST_RUN) pulse(12);
		wait_st(ST_RUN);
	endtask
	initial begin
		#200000;
		miscompares++;
		test_done();
	end
	initial begin
		int n;
		repeat (8) @(posedge mclk_i);
		reset_i <= 1'b0;
		foreach (ra[i]) rd(ra[i], rv[i]);
		wr(ADDR_COOLDOWN, 32'h0);
		wr(ADDR_GOV_OFS, 32'h5A);
		// Zero cooldown keeps every case parked in COOL until its second event arrives.
		for (int i = 0; i < 13; i++) begin
			wr(ADDR_CTRL, 32'(tc[i]));
			to_run();
			pulse(ts[i]);
			repeat (20) @(posedge mclk_i);
			#1;
			chk("cool", 32'(state_o), 32'(ST_COOL));
			pulse(tk[i]);
			chk("cancel", 32'(state_o), 32'(te[i]));
		end
		to_run();
		repeat (2) @(posedge mclk_i);
		#1;
		chk("gov_run", 32'(gov_o), 32'(gsp));
		pulse(4);
		chk("estop", {brk_o, state_o}, {1'b1, ST_STOPPING});
		wait_st(ST_STOPPED);
		repeat (2) @(posedge mclk_i);
		#1;
		chk("gov_ofs", {brk_o, gov_o}, 9'h05A);
		wr(ADDR_COOLDOWN, 32'h3);
		to_run();
		pulse(2);
		repeat (15) @(posedge mclk_i);
		pulse(12);
		pulse(2);
		dwell(ST_COOL, n);
		chk("cool_len", 32'(n > 19 && n < 33), 32'h1);
		wr(ADDR_CTRL, 32'h031);
		to_run();
		th <= 1'b1;
		pulse(2);
		chk("hold", 32'(state_o), 32'(ST_RUN));
		th <= 1'b0;
		low <= 1'b1;
		pulse(2);
		chk("low_stop", 32'(state_o), 32'(ST_COOL));
		low <= 1'b0;
		wr(ADDR_STOPFAIL, 32'h2);
		stuck <= 1'b1;
		pulse(4);
		pulse(5);
		chk("no_start", 32'(state_o), 32'(ST_STOPPING));
		repeat (30) @(posedge mclk_i);
		rd(ADDR_STATUS, 32'h104);
		chk("sfail_pin", 32'(sfail_o), 32'h1);
		stuck <= 1'b0;
		wait_st(ST_STOPPED);
		wr(ADDR_STATUS, 32'h100);
		rd(ADDR_STATUS, 32'h0);
		wr(ADDR_IDLE_STA, 32'h1);
		wr(ADDR_IDLE_STO, 32'h1);
		wr(ADDR_COOLDOWN, 32'h1);
		wr(ADDR_CTRL, 32'h037);
		pulse(5);
		repeat (6) @(posedge mclk_i);
		#1;
		chk("idle_start", 32'(idle_o), 32'h1);
		repeat (70) @(posedge mclk_i);
		#1;
		chk("idle_end", 32'(idle_o), 32'h0);
		pulse(2);
		wait_st(ST_IDLE_STOP);
		// Idle select is registered, so it follows the state by one cycle.
		@(posedge mclk_i);
		#1;
		chk("idle_stop", 32'(idle_o), 32'h1);
		dwell(ST_IDLE_STOP, n);
		chk("istop_len", 32'(n > 49 && n < 63), 32'h1);
		wait_st(ST_STOPPED);
		low <= 1'b1;
		pulse(5);
		repeat (80) @(posedge mclk_i);
		#1;
		chk("low_prio", 32'(idle_o), 32'h1);
		low <= 1'b0;
		repeat (3) @(posedge mclk_i);
		#1;
		chk("nominal", 32'(idle_o), 32'h0);
		wr(ADDR_CTRL, 32'h03F);
		low <= 1'b1;
		inh <= 1'b1;
		repeat (3) @(posedge mclk_i);
		#1;
		chk("oil", {idle_o, inh_o, oil_o}, 3'b110);
		pulse(5);
		repeat (2) @(posedge mclk_i);
		#1;
		chk("int_start", 32'(idle_o), 32'h0);
		low <= 1'b0;
		repeat (2) @(posedge mclk_i);
		low <= 1'b1;
		repeat (3) @(posedge mclk_i);
		pulse(2);
		chk("int_stop", 32'(state_o), 32'(ST_STOPPING));
		test_done();
	end
endmodule // tb_top
`default_nettype wire
